// *** pkg/slwo_consts.svh ***
`ifndef SLWO_CONSTS_SVH
`define SLWO_CONSTS_SVH

// ----------------------------------------
// Register indices; each register owns one aligned 32-bit word
// ----------------------------------------
`define SLWO_IDX_DRIVE       8'hb0
`define SLWO_IDX_FORCE       8'hb4
`define SLWO_IDX_L1_LOW      8'hb6
`define SLWO_IDX_L1_HIGH     8'hb7
`define SLWO_IDX_L2_LOW      8'hb8
`define SLWO_IDX_L2_HIGH     8'hb9

// ----------------------------------------
// Register byte addresses, four times the index
// ----------------------------------------
`define SLWO_ADDR_DRIVE      ({2'b00, `SLWO_IDX_DRIVE, 2'b00})
`define SLWO_ADDR_FORCE      ({2'b00, `SLWO_IDX_FORCE, 2'b00})
`define SLWO_ADDR_L1_LOW     ({2'b00, `SLWO_IDX_L1_LOW, 2'b00})
`define SLWO_ADDR_L1_HIGH    ({2'b00, `SLWO_IDX_L1_HIGH, 2'b00})
`define SLWO_ADDR_L2_LOW     ({2'b00, `SLWO_IDX_L2_LOW, 2'b00})
`define SLWO_ADDR_L2_HIGH    ({2'b00, `SLWO_IDX_L2_HIGH, 2'b00})

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SLWO_BIT_FORCE1      3
`define SLWO_BIT_FORCE2      6
`define SLWO_DRIVE_MSB       3
`define SLWO_RST_BYTE        8'h00
`define SLWO_RST_DRIVE       4'h0

// ----------------------------------------
// Drive current, in mA
// ----------------------------------------
`define SLWO_MA_BASE         6'h10
`define SLWO_MA_B3           6'h10
`define SLWO_MA_B2           6'h08
`define SLWO_MA_B1           6'h04
`define SLWO_MA_B0           6'h02

`endif

// *** pkg/slwo_pkg.sv ***
package slwo_pkg;

    typedef struct packed {
        logic [9:0] first_lane_forced_word;
        logic [9:0] second_lane_forced_word;
        logic       first_lane_word_force;
        logic       second_lane_word_force;
    } slwo_force_t;

    typedef struct packed {
        logic [9:0] lane1;
        logic [9:0] lane2;
    } slwo_lanes_t;

endpackage

// *** hw/slwo_lane_mux.sv ***
`include "slwo_consts.svh"

module slwo_lane_mux (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire slwo_pkg::slwo_force_t i_force,
    input  wire slwo_pkg::slwo_lanes_t i_coded,
    output slwo_pkg::slwo_lanes_t   o_lanes
);

    slwo_pkg::slwo_lanes_t lanes_d;
    slwo_pkg::slwo_lanes_t lanes_q;

    // ----------------------------------------
    // Lane selection
    // ----------------------------------------
    always_comb begin
        lanes_d.lane1 = i_force.first_lane_word_force ?
            i_force.first_lane_forced_word : i_coded.lane1;
        lanes_d.lane2 = i_force.second_lane_word_force ?
            i_force.second_lane_forced_word : i_coded.lane2;
    end

    // Registered so the serializer sees a glitch-free word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lanes_q <= '0;
        end else begin
            lanes_q <= lanes_d;
        end
    end

    assign o_lanes = lanes_q;

    property p_lane1_path;
        @(posedge i_clk) disable iff (i_rst)
        1 |=> o_lanes.lane1 == ($past(i_force.first_lane_word_force) ?
            $past(i_force.first_lane_forced_word) : $past(i_coded.lane1));
    endproperty
    a_lane1_path: assert property (p_lane1_path)
        else $error("lane 1 output mismatch");

    property p_lane2_path;
        @(posedge i_clk) disable iff (i_rst)
        1 |=> o_lanes.lane2 == ($past(i_force.second_lane_word_force) ?
            $past(i_force.second_lane_forced_word) : $past(i_coded.lane2));
    endproperty
    a_lane2_path: assert property (p_lane2_path)
        else $error("lane 2 output mismatch");

    property p_pass_through;
        @(posedge i_clk) disable iff (i_rst)
        !i_force.first_lane_word_force && !i_force.second_lane_word_force
        |=> o_lanes == $past(i_coded);
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("coder output not passed unchanged");

endmodule

// *** hw/slwo_top.sv ***
// Our own choice: register access over APB.
`include "slwo_consts.svh"

// Behaviour
// - Drive current field resets to zero; 16 mA +16*b3 -8*b2 -4*b1 -2*b0.
// - Lane 1 force bit set sends programmed lane 1 word, not coder MSB.
// - Lane 1 word is first byte bits 7:0 then second byte bits 7:6.
// - Lane 2 force bit set sends programmed lane 2 word, not coder LSB.
// - Lane 2 word is first byte bits 7:4 then second byte bits 7:2.
module slwo_top (
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    input  wire logic [3:0]         i_pstrb,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire logic [9:0]         i_coded_lane1,
    input  wire logic [9:0]         i_coded_lane2,
    output logic      [9:0]         o_lane1,
    output logic      [9:0]         o_lane2,
    output logic      [3:0]         o_line_drive_current_sel,
    output logic      [5:0]         o_drive_current_ma
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0]            drive_q;
    logic [7:0]            force_q;
    logic [7:0]            l1_low_q;
    logic [7:0]            l1_high_q;
    logic [7:0]            l2_low_q;
    logic [7:0]            l2_high_q;
    logic [31:0]           rdata_d;
    logic [31:0]           rdata_q;
    logic                  hit_d;
    logic                  err_q;
    logic                  wr_en;
    logic                  acc;
    logic [5:0]            ma_d;
    logic [5:0]            ma_q;
    slwo_pkg::slwo_force_t force_cfg;
    slwo_pkg::slwo_lanes_t coded;
    slwo_pkg::slwo_lanes_t lanes;

    // ----------------------------------------
    // APB access
    // ----------------------------------------
    // Zero-wait slave: every access completes in its first access cycle
    assign acc      = i_psel && i_penable;
    assign wr_en    = acc && i_pwrite && i_pstrb[0];
    assign o_pready = 1'b1;

    always_comb begin
        hit_d   = 1'b1;
        rdata_d = 32'h0000_0000;
        unique case (i_paddr)
            `SLWO_ADDR_DRIVE:   rdata_d[7:0] = drive_q;
            `SLWO_ADDR_FORCE:   rdata_d[7:0] = force_q;
            `SLWO_ADDR_L1_LOW:  rdata_d[7:0] = l1_low_q;
            `SLWO_ADDR_L1_HIGH: rdata_d[7:0] = l1_high_q;
            `SLWO_ADDR_L2_LOW:  rdata_d[7:0] = l2_low_q;
            `SLWO_ADDR_L2_HIGH: rdata_d[7:0] = l2_high_q;
            default:            hit_d = 1'b0;
        endcase
    end

    // Read data registered at setup so it stands through the access phase
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (i_psel && !i_penable) begin
            rdata_q <= rdata_d;
            err_q   <= !hit_d;
        end
    end

    assign o_prdata  = rdata_q;
    assign o_pslverr = acc && err_q;

    // Byte writes land in lane 0 only; upper lanes have nothing behind them
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            drive_q   <= `SLWO_RST_BYTE;
            force_q   <= `SLWO_RST_BYTE;
            l1_low_q  <= `SLWO_RST_BYTE;
            l1_high_q <= `SLWO_RST_BYTE;
            l2_low_q  <= `SLWO_RST_BYTE;
            l2_high_q <= `SLWO_RST_BYTE;
        end else if (wr_en) begin
            unique case (i_paddr)
                `SLWO_ADDR_DRIVE:   drive_q   <= i_pwdata[7:0];
                `SLWO_ADDR_FORCE:   force_q   <= i_pwdata[7:0];
                `SLWO_ADDR_L1_LOW:  l1_low_q  <= i_pwdata[7:0];
                `SLWO_ADDR_L1_HIGH: l1_high_q <= i_pwdata[7:0];
                `SLWO_ADDR_L2_LOW:  l2_low_q  <= i_pwdata[7:0];
                `SLWO_ADDR_L2_HIGH: l2_high_q <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Line driver current
    // ----------------------------------------
    assign o_line_drive_current_sel = drive_q[`SLWO_DRIVE_MSB:0];

    always_comb begin
        ma_d = `SLWO_MA_BASE;
        if (drive_q[3]) ma_d = ma_d + `SLWO_MA_B3;
        if (drive_q[2]) ma_d = ma_d - `SLWO_MA_B2;
        if (drive_q[1]) ma_d = ma_d - `SLWO_MA_B1;
        if (drive_q[0]) ma_d = ma_d - `SLWO_MA_B0;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ma_q <= `SLWO_MA_BASE;
        end else begin
            ma_q <= ma_d;
        end
    end

    assign o_drive_current_ma = ma_q;

    // ----------------------------------------
    // Override words
    // ----------------------------------------
    // Lower address carries the upper bits of each word
    assign force_cfg.first_lane_forced_word =
        {l1_low_q, l1_high_q[7:6]};
    assign force_cfg.second_lane_forced_word =
        {l2_low_q[7:4], l2_high_q[7:2]};
    assign force_cfg.first_lane_word_force  = force_q[`SLWO_BIT_FORCE1];
    assign force_cfg.second_lane_word_force = force_q[`SLWO_BIT_FORCE2];
    assign coded.lane1 = i_coded_lane1;
    assign coded.lane2 = i_coded_lane2;

    slwo_lane_mux u_mux (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_force (force_cfg),
        .i_coded (coded),
        .o_lanes (lanes)
    );

    assign o_lane1 = lanes.lane1;
    assign o_lane2 = lanes.lane2;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_drive_reset;
        @(posedge i_clk)
        i_rst |=> o_line_drive_current_sel == `SLWO_RST_DRIVE
            && o_drive_current_ma == `SLWO_MA_BASE;
    endproperty
    a_drive_reset: assert property (p_drive_reset)
        else $error("drive current not 16 mA after reset");

    property p_drive_ma;
        @(posedge i_clk) disable iff (i_rst)
        1 |=> o_drive_current_ma ==
            6'(16 + 16 * $past(drive_q[3]) - 8 * $past(drive_q[2])
               - 4 * $past(drive_q[1]) - 2 * $past(drive_q[0]));
    endproperty
    a_drive_ma: assert property (p_drive_ma)
        else $error("drive current formula wrong");

    property p_l1_word;
        @(posedge i_clk) disable iff (i_rst)
        force_q[3] ##1 force_q[3] |->
            o_lane1 == {$past(l1_low_q), $past(l1_high_q[7:6])};
    endproperty
    a_l1_word: assert property (p_l1_word)
        else $error("lane 1 forced word assembly wrong");

    property p_l2_word;
        @(posedge i_clk) disable iff (i_rst)
        force_q[6] ##1 force_q[6] |->
            o_lane2 == {$past(l2_low_q[7:4]), $past(l2_high_q[7:2])};
    endproperty
    a_l2_word: assert property (p_l2_word)
        else $error("lane 2 forced word assembly wrong");

    property p_force_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_FORCE && i_pwdata[3]
        |=> ##1 o_lane1 == {$past(l1_low_q), $past(l1_high_q[7:6])};
    endproperty
    a_force_write: assert property (p_force_write)
        else $error("lane 1 force not applied two cycles after write");

    property p_l2_release;
        @(posedge i_clk) disable iff (i_rst)
        !force_q[6] |=> o_lane2 == $past(i_coded_lane2);
    endproperty
    a_l2_release: assert property (p_l2_release)
        else $error("lane 2 not passing coder output");

    property p_l1_release;
        @(posedge i_clk) disable iff (i_rst)
        !force_q[3] |=> o_lane1 == $past(i_coded_lane1);
    endproperty
    a_l1_release: assert property (p_l1_release)
        else $error("lane 1 not passing coder output");

    // ----------------------------------------
    // Register write checks
    // ----------------------------------------
    property p_drive_sel_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_DRIVE
        |=> o_line_drive_current_sel == $past(i_pwdata[`SLWO_DRIVE_MSB:0]);
    endproperty
    a_drive_sel_write: assert property (p_drive_sel_write)
        else $error("drive current select not written");

    property p_drive_range;
        @(posedge i_clk) disable iff (i_rst)
        o_drive_current_ma >= `SLWO_MA_B0
            && o_drive_current_ma <= `SLWO_MA_BASE + `SLWO_MA_B3;
    endproperty
    a_drive_range: assert property (p_drive_range)
        else $error("drive current outside 2 to 32 mA");

    property p_drive_hold;
        @(posedge i_clk) disable iff (i_rst)
        !(wr_en && i_paddr == `SLWO_ADDR_DRIVE)
        |=> $stable(o_line_drive_current_sel);
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("drive current select changed without a write");

    property p_force_bits;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_FORCE |=>
            force_cfg.first_lane_word_force ==
                $past(i_pwdata[`SLWO_BIT_FORCE1])
            && force_cfg.second_lane_word_force ==
                $past(i_pwdata[`SLWO_BIT_FORCE2]);
    endproperty
    a_force_bits: assert property (p_force_bits)
        else $error("lane force bits not taken from the write");

    property p_force2_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_FORCE && i_pwdata[`SLWO_BIT_FORCE2]
        |=> ##1 o_lane2 == {$past(l2_low_q[7:4]), $past(l2_high_q[7:2])};
    endproperty
    a_force2_write: assert property (p_force2_write)
        else $error("lane 2 force not applied two cycles after write");

    property p_l1_low_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_L1_LOW
        |=> force_cfg.first_lane_forced_word[9:2] == $past(i_pwdata[7:0]);
    endproperty
    a_l1_low_write: assert property (p_l1_low_write)
        else $error("lane 1 word upper bits not written");

    property p_l1_high_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_L1_HIGH
        |=> force_cfg.first_lane_forced_word[1:0] == $past(i_pwdata[7:6]);
    endproperty
    a_l1_high_write: assert property (p_l1_high_write)
        else $error("lane 1 word lower bits not written");

    property p_l1_hold;
        @(posedge i_clk) disable iff (i_rst)
        !(wr_en && (i_paddr == `SLWO_ADDR_L1_LOW
                    || i_paddr == `SLWO_ADDR_L1_HIGH))
        |=> $stable(force_cfg.first_lane_forced_word);
    endproperty
    a_l1_hold: assert property (p_l1_hold)
        else $error("lane 1 word changed without a write");

    property p_l2_low_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_L2_LOW
        |=> force_cfg.second_lane_forced_word[9:6] == $past(i_pwdata[7:4]);
    endproperty
    a_l2_low_write: assert property (p_l2_low_write)
        else $error("lane 2 word upper bits not written");

    property p_l2_high_write;
        @(posedge i_clk) disable iff (i_rst)
        wr_en && i_paddr == `SLWO_ADDR_L2_HIGH
        |=> force_cfg.second_lane_forced_word[5:0] == $past(i_pwdata[7:2]);
    endproperty
    a_l2_high_write: assert property (p_l2_high_write)
        else $error("lane 2 word lower bits not written");

    property p_l2_hold;
        @(posedge i_clk) disable iff (i_rst)
        !(wr_en && (i_paddr == `SLWO_ADDR_L2_LOW
                    || i_paddr == `SLWO_ADDR_L2_HIGH))
        |=> $stable(force_cfg.second_lane_forced_word);
    endproperty
    a_l2_hold: assert property (p_l2_hold)
        else $error("lane 2 word changed without a write");

endmodule

// *** tb/slwo_rx_model.sv ***
module slwo_rx_model (
    input  wire logic       i_clk,
    input  wire logic [9:0] i_lane1,
    input  wire logic [9:0] i_lane2,
    output logic      [9:0] o_word1,
    output logic      [9:0] o_word2
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Symbol capture
    // ----------------------------------------
    // No comma search: raw symbols are kept so forced words stay visible
    always_ff @(posedge i_clk) begin
        o_word1 <= i_lane1;
        o_word2 <= i_lane2;
    end
endmodule

// *** tb/slwo_top_tb.sv ***
`include "slwo_consts.svh"

module slwo_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0;
    logic [3:0]  i_pstrb = 4'hf;
    logic [9:0]  i_coded_lane1 = 10'h000;
    logic [9:0]  i_coded_lane2 = 10'h000;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [9:0]  o_lane1;
    logic [9:0]  o_lane2;
    logic [9:0]  rx1;
    logic [9:0]  rx2;
    logic [3:0]  o_sel;
    logic [5:0]  o_ma;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  rm [int];
    logic [19:0] exp_q [$];
    int          adr [6] = '{`SLWO_ADDR_DRIVE, `SLWO_ADDR_FORCE,
                             `SLWO_ADDR_L1_LOW, `SLWO_ADDR_L1_HIGH,
                             `SLWO_ADDR_L2_LOW, `SLWO_ADDR_L2_HIGH};
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #4 i_clk = ~i_clk;
    slwo_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_coded_lane1(i_coded_lane1), .i_coded_lane2(i_coded_lane2),
        .o_lane1(o_lane1), .o_lane2(o_lane2),
        .o_line_drive_current_sel(o_sel), .o_drive_current_ma(o_ma));
    slwo_rx_model rx (.i_clk(i_clk), .i_lane1(o_lane1), .i_lane2(o_lane2),
        .o_word1(rx1), .o_word2(rx2));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input int a, input bit wr, input int wd,
                       input bit [3:0] st);
        int k;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a[11:0];
        i_pwdata <= wd;
        i_pstrb <= st;
        @(posedge i_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 16);
        rd = o_prdata;
        err = o_pslverr;
        if (k >= 16 && o_pready !== 1'b1) begin
            n_mismatch++;
            complete_run();
        end else begin
            i_psel <= 1'b0;
            i_penable <= 1'b0;
            // Model takes only mapped, byte-enabled writes
            if (wr && rm.exists(a) && st[0])
                rm[a] = wd[7:0];
        end
    endtask
    task automatic rdchk(input int a);
        apb(a, 1'b0, 0, 4'hf);
        chk(rd, rm.exists(a) ? 32'(rm[a]) : 32'h0);
        chk(err, !rm.exists(a));
    endtask
    task automatic run_lanes(input int n);
        logic [9:0] c1;
        logic [9:0] c2;
        logic [9:0] w1;
        logic [9:0] w2;
        logic       f1;
        logic       f2;
        exp_q.delete();
        w1 = {rm[`SLWO_ADDR_L1_LOW], rm[`SLWO_ADDR_L1_HIGH][7:6]};
        w2 = {rm[`SLWO_ADDR_L2_LOW][7:4], rm[`SLWO_ADDR_L2_HIGH][7:2]};
        f1 = rm[`SLWO_ADDR_FORCE][`SLWO_BIT_FORCE1];
        f2 = rm[`SLWO_ADDR_FORCE][`SLWO_BIT_FORCE2];
        repeat (n) begin
            @(posedge i_clk);
            // Three stages: stimulus, lane register, receiver capture
            if (exp_q.size() == 3)
                chk({rx1, rx2}, exp_q.pop_front());
            c1 = 10'($urandom);
            c2 = 10'($urandom);
            i_coded_lane1 <= c1;
            i_coded_lane2 <= c2;
            exp_q.push_back({f1 ? w1 : c1, f2 ? w2 : c2});
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int ma;
        void'($urandom(32'h82ef));
        foreach (adr[i]) rm[adr[i]] = 8'h00;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (adr[i]) rdchk(adr[i]);
        chk(o_ma, 32'h10);
        chk(o_sel, 32'h0);
        $display("test reset done");
        for (int v = 0; v < 16; v++) begin
            apb(`SLWO_ADDR_DRIVE, 1'b1, v, 4'hf);
            repeat (2) @(posedge i_clk);
            ma = 16 + 16 * v[3] - 8 * v[2] - 4 * v[1] - 2 * v[0];
            chk(o_sel, v);
            chk(o_ma, ma);
        end
        rdchk(`SLWO_ADDR_DRIVE);
        @(posedge i_clk);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        foreach (adr[i]) rm[adr[i]] = 8'h00;
        repeat (2) @(posedge i_clk);
        chk(o_ma, 32'h10);
        chk(o_sel, 32'h0);
        rdchk(`SLWO_ADDR_DRIVE);
        $display("test drive current done");
        for (int t = 0; t < 4; t++) begin
            for (int i = 2; i < 6; i++)
                apb(adr[i], 1'b1, $urandom, 4'hf);
            apb(`SLWO_ADDR_FORCE, 1'b1, {t[1], 2'b00, t[0], 3'b000}, 4'hf);
            foreach (adr[i]) rdchk(adr[i]);
            run_lanes(12);
        end
        $display("test lane override done");
        // Word between two registers, and a byte offset that is no word
        apb(12'h2d4, 1'b1, 32'hff, 4'hf);
        chk(err, 1'b1);
        apb(`SLWO_ADDR_L1_LOW, 1'b1, 32'h5a, 4'h0);
        rdchk(12'h2d4);
        rdchk(12'h2d9);
        rdchk(`SLWO_ADDR_L1_LOW);
        run_lanes(8);
        $display("test refused writes done");
        complete_run();
    end
endmodule
